// [hw/spcf_top.sv]
`timescale 1ns/100ps
`include "spcf_consts.svh"
module spcf_top (
  input  wire logic                  aclk,           // System clock.
  input  wire logic                  aresetn,        // Synchronous reset, active low.
  input  wire logic                  awvalid,        // Write address valid.
  output logic                       awready,        // Write address ready.
  input  wire logic [11:0]           awaddr,         // Write byte address.
  input  wire logic                  wvalid,         // Write data valid.
  output logic                       wready,         // Write data ready.
  input  wire logic [31:0]           wdata,          // Write data.
  input  wire logic [3:0]            wstrb,          // Write byte strobes.
  output logic                       bvalid,         // Write response valid.
  input  wire logic                  bready,         // Write response ready.
  output logic [1:0]                 bresp,          // Write response code.
  input  wire logic                  arvalid,        // Read address valid.
  output logic                       arready,        // Read address ready.
  input  wire logic [11:0]           araddr,         // Read byte address.
  output logic                       rvalid,         // Read data valid.
  input  wire logic                  rready,         // Read data ready.
  output logic [31:0]                rdata,          // Read data.
  output logic [1:0]                 rresp,          // Read response code.
  input  wire spcf_pkg::spcf_rx_evt_t p1_rx,         // Port-1 receive frame events.
  input  wire logic                  p1_tx_done,     // Port-1 frame sent pulse.
  input  wire logic                  p1_int_enable,  // Port-1 interrupt enable.
  input  wire logic                  t3_overflow,    // Timer 3 overflow pulse.
  input  wire logic                  p0_frame_err,   // Port-0 framing error pulse.
  input  wire logic                  p0_t1_baud_src, // Port-0 baud taken from Timer 1.
  output spcf_pkg::spcf_p1_out_t     p1_out,         // Port-1 controls to datapath.
  output spcf_pkg::spcf_p0_out_t     p0_out          // Port-0 controls to datapath.
);
  import spcf_pkg::*;

  spcf_state_t q;
  spcf_state_t d;
  logic        do_wr;
  logic        wr_scon1;
  spcf_mode_t  p1_mode;
  logic        p1_accept;

  // Bit 7 shows the error flag or the upper mode bit, as the select says.
  function automatic logic bit7_view(logic sel, logic fe, logic mode_hi);
    return sel ? fe : mode_hi;
  endfunction

  function automatic logic [9:0] rd_word(logic [9:0] idx, spcf_state_t s);
    logic [9:0] r;
    r = {`SPCF_RESP_OKAY, 8'h00};
    if (idx == `SPCF_IDX_POWER_AND_SERIAL0_CONTROL) begin
      r[7:0] = s.power_and_serial0_control & `SPCF_POWER_AND_SERIAL0_CONTROL_WMASK;
    end else if (idx == `SPCF_IDX_SCON0) begin
      r[7:0] = {bit7_view(s.power_and_serial0_control[`SPCF_BIT_FE_ACCESS], s.fe0, s.scon0[7]), s.scon0[6:0]};
    end else if (idx == `SPCF_IDX_TIMER3_CONTROL) begin
      r[7:0] = s.timer3_control;
    end else if (idx == `SPCF_IDX_SCON1) begin
      r[7:0] = {bit7_view(s.timer3_control[`SPCF_BIT_FE_ACCESS], s.fe1, s.scon1[7]), s.scon1[6:0]};
    end else begin
      r[9:8] = `SPCF_RESP_SLVERR;
    end
    return r;
  endfunction

  always_comb begin
    d         = q;
    p1_mode   = spcf_mode_t'(q.scon1[7:6]);
    do_wr     = q.aw_have && q.w_have && !q.bvalid;
    wr_scon1  = do_wr && q.w_en && (q.aw_idx == `SPCF_IDX_SCON1);
    // The filter passes everything when off; when on it needs the ninth or stop bit and an address hit.
    p1_accept = !q.scon1[`SPCF_BIT_MPE] || (p1_rx.ninth && p1_rx.match);

    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_idx  = awaddr[11:2];
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata[7:0];
      d.w_en   = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (do_wr) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `SPCF_RESP_OKAY;
      if (q.aw_idx == `SPCF_IDX_POWER_AND_SERIAL0_CONTROL) begin
        if (q.w_en) begin
          d.power_and_serial0_control = q.w_data & `SPCF_POWER_AND_SERIAL0_CONTROL_WMASK;
        end
      end else if (q.aw_idx == `SPCF_IDX_SCON0) begin
        if (q.w_en) begin
          d.scon0[6:0] = q.w_data[6:0];
          if (q.power_and_serial0_control[`SPCF_BIT_FE_ACCESS]) begin
            d.fe0 = q.w_data[7];
          end else begin
            d.scon0[7] = q.w_data[7];
          end
        end
      end else if (q.aw_idx == `SPCF_IDX_TIMER3_CONTROL) begin
        if (q.w_en) begin
          d.timer3_control = q.w_data;
        end
      end else if (q.aw_idx == `SPCF_IDX_SCON1) begin
        if (q.w_en) begin
          d.scon1[6:0] = q.w_data[6:0];
          if (q.timer3_control[`SPCF_BIT_FE_ACCESS]) begin
            d.fe1 = q.w_data[7];
          end else begin
            d.scon1[7] = q.w_data[7];
          end
        end
      end else begin
        d.bresp = `SPCF_RESP_SLVERR;
      end
    end

    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      {d.rresp, d.rdata} = rd_word(araddr[11:2], q);
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end

    // Hardware events come after the software write so that a set beats a clear in the same cycle.
    if (p1_rx.frame_err) begin
      d.fe1 = 1'b1;
    end
    if (p0_frame_err) begin
      d.fe0 = 1'b1;
    end
    if (p1_tx_done) begin
      d.scon1[`SPCF_BIT_TI] = 1'b1;
    end
    if (p1_rx.done && q.scon1[`SPCF_BIT_REN]) begin
      if (p1_mode == SPCF_M0) begin
        d.scon1[`SPCF_BIT_RI] = 1'b1;
      end else if (p1_accept) begin
        d.scon1[`SPCF_BIT_RI]  = 1'b1;
        d.scon1[`SPCF_BIT_RB8] = p1_rx.ninth;
      end
    end

    // The divider runs freely on overflows; only modes 1 and 3 take its tick.
    d.p1.bit_tick = 1'b0;
    if (t3_overflow) begin
      d.tick_cnt = q.tick_cnt + 4'h1;
      d.p1.bit_tick = (q.tick_cnt == `SPCF_T3_LAST) && q.scon1[`SPCF_BIT_MODE_LO];
    end

    d.p1.mode        = spcf_mode_t'(d.scon1[7:6]);
    d.p1.rx_enable   = d.scon1[`SPCF_BIT_REN];
    d.p1.rx_start_ok = d.scon1[`SPCF_BIT_REN] && (d.p1.mode != SPCF_M0 || !d.scon1[`SPCF_BIT_RI]);
    d.p1.tx_ninth    = d.scon1[`SPCF_BIT_MODE_HI] && d.scon1[`SPCF_BIT_TB8];
    d.p1.baud_double = d.timer3_control[`SPCF_BIT_BAUD_DBL] && (d.p1.mode == SPCF_M2);
    d.p1.irq         = p1_int_enable && (d.scon1[`SPCF_BIT_TI] || d.scon1[`SPCF_BIT_RI]);
    d.p0.mode        = spcf_mode_t'(d.scon0[7:6]);
    d.p0.baud_double = d.power_and_serial0_control[`SPCF_BIT_BAUD_DBL] &&
                       (d.p0.mode == SPCF_M2 || (d.scon0[`SPCF_BIT_MODE_LO] && p0_t1_baud_src));

    d.awready = !d.aw_have;
    d.wready  = !d.w_have;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign arready = q.arready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign rvalid  = q.rvalid;
  assign rresp   = q.rresp;
  assign rdata   = {24'h000000, q.rdata};
  assign p1_out  = q.p1;
  assign p0_out  = q.p0;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rx_open;
    p1_rx.done && q.scon1[`SPCF_BIT_REN] && p1_mode != SPCF_M0 && !q.scon1[`SPCF_BIT_MPE];
  endsequence
  sequence s_rx_reject;
    p1_rx.done && p1_mode != SPCF_M0 && q.scon1[`SPCF_BIT_MPE] && !(p1_rx.ninth && p1_rx.match);
  endsequence
  sequence s_tx_flag_up;
    p1_tx_done && p1_int_enable ##1 q.scon1[`SPCF_BIT_TI];
  endsequence

  a_fe1_set_sticky: assert property (p1_rx.frame_err |=> q.fe1)
    else $error("port-1 framing error flag not set");
  a_mode_hi_kept: assert property (wr_scon1 && q.timer3_control[`SPCF_BIT_FE_ACCESS] |=> $stable(q.scon1[7]))
    else $error("mode bit changed while bit 7 maps to error flag");
  a_rx_open_take: assert property (s_rx_open |=> q.scon1[`SPCF_BIT_RI] && q.scon1[`SPCF_BIT_RB8] == $past(p1_rx.ninth))
    else $error("unfiltered frame not accepted");
  a_rx_filter_drop: assert property ((s_rx_reject and (!q.scon1[`SPCF_BIT_RI] && !wr_scon1))
                                     |=> !q.scon1[`SPCF_BIT_RI] && $stable(q.scon1[`SPCF_BIT_RB8]))
    else $error("filtered frame wrongly accepted");
  a_rx_disabled: assert property (p1_rx.done && !q.scon1[`SPCF_BIT_REN] && !q.scon1[`SPCF_BIT_RI] && !wr_scon1
                                  |=> !q.scon1[`SPCF_BIT_RI])
    else $error("frame accepted with reception disabled");
  a_m0_start_gate: assert property (p1_out.mode == SPCF_M0 && q.scon1[`SPCF_BIT_RI] |-> !p1_out.rx_start_ok)
    else $error("mode 0 start allowed with receive flag set");
  a_tx_ninth_out: assert property (p1_out.tx_ninth == (p1_out.mode[1] && q.scon1[`SPCF_BIT_TB8]))
    else $error("ninth transmit bit wrong for mode");
  a_done_sticky: assert property (q.scon1[`SPCF_BIT_TI] && !wr_scon1 |=> q.scon1[`SPCF_BIT_TI])
    else $error("transmit flag cleared without software");
  a_irq_follows: assert property (s_tx_flag_up |-> p1_out.irq)
    else $error("interrupt request missing after transmit done");
  a_tick_div16: assert property (p1_out.bit_tick |-> $past(t3_overflow) && $past(q.tick_cnt) == `SPCF_T3_LAST)
    else $error("bit tick not on sixteenth overflow");
  a_p1_dbl_mode2: assert property (p1_out.baud_double |-> p1_out.mode == SPCF_M2)
    else $error("port-1 doubling outside mode 2");
  a_p0_dbl_mode: assert property (p0_out.baud_double |-> q.power_and_serial0_control[`SPCF_BIT_BAUD_DBL])
    else $error("port-0 doubling without its enable");
  a_m0_rx_take: assert property (p1_rx.done && q.scon1[`SPCF_BIT_REN] && p1_mode == SPCF_M0 |=> q.scon1[`SPCF_BIT_RI])
    else $error("mode 0 frame end did not set receive flag");
  a_ti_set: assert property (p1_tx_done |=> q.scon1[`SPCF_BIT_TI])
    else $error("transmit flag not set after frame sent");
  a_fe0_set_sticky: assert property (p0_frame_err |=> q.fe0)
    else $error("port-0 framing error flag not set");
endmodule

// [shared/spcf_consts.svh]
`ifndef SPCF_CONSTS_SVH
`define SPCF_CONSTS_SVH
// Register indices; byte address is four times the index.
`define SPCF_IDX_POWER_AND_SERIAL0_CONTROL      10'h087
`define SPCF_IDX_SCON0     10'h098
`define SPCF_IDX_TIMER3_CONTROL     10'h0c4
`define SPCF_IDX_SCON1     10'h0f8
// Field positions.
`define SPCF_BIT_MODE_HI   7
`define SPCF_BIT_MODE_LO   6
`define SPCF_BIT_MPE       5
`define SPCF_BIT_REN       4
`define SPCF_BIT_TB8       3
`define SPCF_BIT_RB8       2
`define SPCF_BIT_TI        1
`define SPCF_BIT_RI        0
`define SPCF_BIT_BAUD_DBL  7
`define SPCF_BIT_FE_ACCESS 6
`define SPCF_POWER_AND_SERIAL0_CONTROL_WMASK    8'hdf
// Reset values.
`define SPCF_RST_POWER_AND_SERIAL0_CONTROL      8'h00
`define SPCF_RST_SERIAL_PORT0_CONTROL      8'h00
`define SPCF_RST_TIMER3_CONTROL     8'h00
// Timer 3 overflows per port-1 bit in modes 1 and 3.
`define SPCF_T3_DIV        16
`define SPCF_T3_LAST       4'hf
// Bus answers.
`define SPCF_RESP_OKAY     2'h0
`define SPCF_RESP_SLVERR   2'h2
`endif

// [shared/spcf_pkg.sv]
package spcf_pkg;
  typedef enum logic [1:0] {SPCF_M0, SPCF_M1, SPCF_M2, SPCF_M3} spcf_mode_t;
  typedef struct packed {
    logic done;
    logic ninth;
    logic match;
    logic frame_err;
  } spcf_rx_evt_t;
  typedef struct packed {
    spcf_mode_t mode;
    logic       rx_enable;
    logic       rx_start_ok;
    logic       tx_ninth;
    logic       baud_double;
    logic       bit_tick;
    logic       irq;
  } spcf_p1_out_t;
  typedef struct packed {
    spcf_mode_t mode;
    logic       baud_double;
  } spcf_p0_out_t;
  typedef struct packed {
    logic         awready;
    logic         wready;
    logic         arready;
    logic         aw_have;
    logic [9:0]   aw_idx;
    logic         w_have;
    logic [7:0]   w_data;
    logic         w_en;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [1:0]   rresp;
    logic [7:0]   rdata;
    logic [7:0]   power_and_serial0_control;
    logic [7:0]   scon0;
    logic         fe0;
    logic [7:0]   timer3_control;
    logic [7:0]   scon1;
    logic         fe1;
    logic [3:0]   tick_cnt;
    spcf_p1_out_t p1;
    spcf_p0_out_t p0;
  } spcf_state_t;
endpackage

// [verif/spcf_remote_model.sv]
`timescale 1ns/100ps
module spcf_remote_model (
  input  wire logic              aclk,         // System clock.
  output spcf_pkg::spcf_rx_evt_t p1_rx,        // Frame end events.
  output logic                   p1_tx_done,   // Frame sent pulse.
  output logic                   t3_overflow,  // Timer 3 overflow pulse.
  output logic                   p0_frame_err  // Port-0 fault pulse.
);
  import spcf_pkg::*;
  logic [6:0] ev_q = 7'h00;
  assign {p1_rx, p1_tx_done, t3_overflow, p0_frame_err} = ev_q;
  // Bits: done, ninth, match, port-1 fault, sent, overflow, port-0 fault.
  // Ninth and match are only valid with done, so they flip between frames.
  task automatic pulse(input logic [6:0] v);
    @(posedge aclk);
    ev_q <= v;
    @(posedge aclk);
    ev_q <= {1'b0, ~v[5:4], 4'h0};
  endtask
endmodule

// [verif/spcf_top_test.sv]
`timescale 1ns/100ps
`include "spcf_consts.svh"
module spcf_top_test;
  import spcf_pkg::*;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic         ie = 1'b1;
  logic         t1src = 1'b0;
  logic [3:0]   strb = 4'h1;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]  wdata = 32'h0, rdata, rd;
  logic [1:0]   bresp, rresp, resp;
  spcf_rx_evt_t p1_rx;
  logic         p1_tx_done, t3_overflow, p0_frame_err;
  spcf_p1_out_t p1_out;
  spcf_p0_out_t p0_out;
  int           fails = 0, samples_checked = 0, ticks = 0;

  spcf_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(strb),
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .p1_rx,
    .p1_tx_done, .p1_int_enable(ie), .t3_overflow, .p0_frame_err, .p0_t1_baud_src(t1src), .p1_out, .p0_out);
  spcf_remote_model u_far (.aclk, .p1_rx, .p1_tx_done, .t3_overflow, .p0_frame_err);

  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) if (p1_out.bit_tick === 1'b1) ticks <= ticks + 1;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 64) begin
      fails++;
      finish_test;
    end
  endtask
  // Handshakes are judged at the falling edge, where flop outputs equal what the next rising edge samples.
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic a = 1'b0, w = 1'b0, b = 1'b0;
    int   n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      guard(n);
    end
  endtask
  task automatic rchk(input string nm, input logic [9:0] idx, input logic [7:0] e);
    logic a = 1'b0, r = 1'b0;
    int   n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
      guard(n);
    end
    check(nm, rd, {24'h0, e});
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("scon1_reset", `SPCF_IDX_SCON1, 8'h00);
    rchk("timer3_control_reset", `SPCF_IDX_TIMER3_CONTROL, 8'h00);
    rchk("unmapped", 10'h001, 8'h00);
    check("unmapped_resp", resp, `SPCF_RESP_SLVERR);
    wr(`SPCF_IDX_SCON1, 8'h50);
    @(negedge aclk);
    check("mode1", p1_out.mode, SPCF_M1);
    check("rx_enable", p1_out.rx_enable, 1'b1);
    repeat (15) u_far.pulse(7'h02);
    repeat (2) @(negedge aclk);
    check("ticks15", ticks, 0);
    u_far.pulse(7'h02);
    repeat (2) @(negedge aclk);
    check("ticks16", ticks, 1);
    u_far.pulse(7'h40);
    rchk("m1_open", `SPCF_IDX_SCON1, 8'h51);
    wr(`SPCF_IDX_SCON1, 8'h70);
    u_far.pulse(7'h50);
    rchk("m1_no_stop", `SPCF_IDX_SCON1, 8'h70);
    u_far.pulse(7'h60);
    rchk("m1_no_match", `SPCF_IDX_SCON1, 8'h70);
    u_far.pulse(7'h70);
    rchk("m1_match", `SPCF_IDX_SCON1, 8'h75);
    wr(`SPCF_IDX_SCON1, 8'h40);
    u_far.pulse(7'h70);
    rchk("rx_off", `SPCF_IDX_SCON1, 8'h40);
    wr(`SPCF_IDX_SCON1, 8'hd8);
    @(negedge aclk);
    check("mode3", p1_out.mode, SPCF_M3);
    check("tx_ninth3", p1_out.tx_ninth, 1'b1);
    u_far.pulse(7'h40);
    u_far.pulse(7'h04);
    rchk("m3_open", `SPCF_IDX_SCON1, 8'hdb);
    check("irq_on", p1_out.irq, 1'b1);
    wr(`SPCF_IDX_SCON1, 8'hd8);
    rchk("sw_clear", `SPCF_IDX_SCON1, 8'hd8);
    check("irq_off", p1_out.irq, 1'b0);
    ie <= 1'b0;
    u_far.pulse(7'h04);
    rchk("masked_ti", `SPCF_IDX_SCON1, 8'hda);
    check("irq_masked", p1_out.irq, 1'b0);
    wr(`SPCF_IDX_SCON1, 8'h58);
    @(negedge aclk);
    check("tx_ninth1", p1_out.tx_ninth, 1'b0);
    wr(`SPCF_IDX_TIMER3_CONTROL, 8'hc0);
    rchk("timer3_control", `SPCF_IDX_TIMER3_CONTROL, 8'hc0);
    strb <= 4'h0;
    wr(`SPCF_IDX_TIMER3_CONTROL, 8'h00);
    strb <= 4'h1;
    rchk("timer3_control_nostrb", `SPCF_IDX_TIMER3_CONTROL, 8'hc0);
    u_far.pulse(7'h08);
    rchk("fe1_view", `SPCF_IDX_SCON1, 8'hd8);
    check("fe1_mode", p1_out.mode, SPCF_M1);
    wr(`SPCF_IDX_SCON1, 8'h58);
    rchk("fe1_clear", `SPCF_IDX_SCON1, 8'h58);
    wr(`SPCF_IDX_SCON1, 8'h10);
    u_far.pulse(7'h40);
    rchk("m0_rx", `SPCF_IDX_SCON1, 8'h11);
    check("m0_start_gate", p1_out.rx_start_ok, 1'b0);
    wr(`SPCF_IDX_POWER_AND_SERIAL0_CONTROL, 8'hff);
    rchk("power_and_serial0_control", `SPCF_IDX_POWER_AND_SERIAL0_CONTROL, 8'hdf);
    u_far.pulse(7'h01);
    rchk("fe0_view", `SPCF_IDX_SCON0, 8'h80);
    check("p0_mode", p0_out.mode, SPCF_M0);
    t1src <= 1'b1;
    wr(`SPCF_IDX_SCON0, 8'h40);
    @(negedge aclk);
    check("p0_dbl_t1", p0_out.baud_double, 1'b1);
    t1src <= 1'b0;
    repeat (2) @(negedge aclk);
    check("p0_dbl_off", p0_out.baud_double, 1'b0);
    finish_test;
  end
endmodule
